// ==== light_prox_pkg.sv ====
// Shared constants for the light and proximity measurement sequencer
`default_nettype none
package light_prox_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned STEP_NS         = 2_720_000;
  localparam int unsigned STEP_CYCLES     = STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_PERIOD_NS = 16_300;
  localparam int unsigned PULSE_CYCLES    = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned LED_ON_NS       = 7_200;
  localparam int unsigned LED_ON_CYCLES   = LED_ON_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_W         = 12;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE     = 8'h00;
  localparam logic [7:0] ADDR_LIGHT_TIME = 8'h01;
  localparam logic [7:0] ADDR_WAIT_TIME  = 8'h03;
  localparam logic [7:0] ADDR_PULSES     = 8'h0e;
  localparam logic [7:0] ADDR_GAIN       = 8'h0f;
  localparam logic [7:0] ADDR_STATUS     = 8'h13;
  localparam logic [7:0] ADDR_VIS_LO     = 8'h14;
  localparam logic [7:0] ADDR_VIS_HI     = 8'h15;
  localparam logic [7:0] ADDR_IR_LO      = 8'h16;
  localparam logic [7:0] ADDR_IR_HI      = 8'h17;

  localparam int unsigned BIT_POWER    = 0;
  localparam int unsigned BIT_LIGHT_EN = 1;
  localparam int unsigned BIT_PROX_EN  = 2;
  localparam int unsigned BIT_WAIT_EN  = 3;

  localparam logic [7:0] SETTING_RST = 8'hff;
  localparam logic [7:0] PULSES_RST  = 8'h00;
  localparam logic [1:0] GAIN_RST    = 2'h0;
  localparam logic [8:0] STEPS_FULL  = 9'h100;
  localparam logic [15:0] COUNT_FULL = 16'hffff;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_SLEEP = 5'b0_0001,
    ST_START = 5'b0_0010,
    ST_PROX  = 5'b0_0100,
    ST_WAIT  = 5'b0_1000,
    ST_LIGHT = 5'b1_0000
  } seq_state_e;

endpackage
`default_nettype wire

// ==== light_prox_sequencer.sv ====
// Measurement sequencer with register port for the light/proximity sensor
//
// Decided for this implementation: the plain strobed port and the address map.
`default_nettype none
// Function
// - After reset the sequencer sleeps and measures nothing until enabled.
// - Setting the power bit moves the sequencer from sleep to start at once.
// - From start it walks proximity, wait, light in order, running enabled.
// - Clearing the power bit lets a running conversion finish, then sleeps.
// - The power bit is bit zero of the register at address zero.
// - Both light channels integrate over exactly the same interval.
// - Both channel counts move to data registers through a double buffer.
// - After the transfer the sequencer advances on its own.
// - Light integration lasts (256 - setting) steps of 2.72 ms.
// - An enabled wait lasts 1 to 256 steps of 2.72 ms from its setting.
// - Each step adds at most 1023 counts to a channel accumulator.
// - An accumulator saturates at 65535 instead of wrapping.
// - Proximity emits 0 to 255 LED pulses before its conversion.
module light_prox_sequencer
  import light_prox_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  // Converter counts per step
  input  wire logic [9:0] visible_channel_count_i,
  input  wire logic [9:0] infrared_channel_count_i,
  // Analog front end controls
  output logic            light_integrate_o,
  output logic      [1:0] light_gain_o,
  output logic            led_pulse_o,
  output logic            prox_convert_o,
  output logic            sleep_o
);

  localparam int unsigned STEP_W = $clog2(STEP_CYCLES_P + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES_P - 1);
  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSE_CYCLES - 1);
  localparam logic [PULSE_W-1:0] LED_ON = PULSE_W'(LED_ON_CYCLES);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    seq_state_e        state;
    logic              power_on_bit;
    logic              light_en;
    logic              proximity_enable_bit;
    logic              wait_en;
    logic [7:0]        light_integration_setting;
    logic [7:0]        wait_time_setting;
    logic [7:0]        pulse_setting;
    logic [1:0]        light_gain_setting;
    logic [STEP_W-1:0] tick_cnt;
    logic [8:0]        step_cnt;
    logic [7:0]        pulse_cnt;
    logic [PULSE_W-1:0] sub_cnt;
    logic [15:0]       vis_acc;
    logic [15:0]       ir_acc;
    logic [15:0]       visible_channel_value;
    logic [15:0]       infrared_channel_value;
    logic [7:0]        vis_hi_shadow;
    logic [7:0]        ir_hi_shadow;
    logic              light_valid;
    logic [7:0]        rdata;
  } seq_s;

  seq_s cur;
  seq_s next_cur;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        pulses_done;
    logic [16:0] vis_sum;
    logic [16:0] ir_sum;
    logic [8:0]  light_steps;
    logic [8:0]  wait_steps;
    logic        light_done;
    seq_state_e  after_prox;
    seq_state_e  after_wait;
    seq_state_e  from_start;
    tick        = (cur.tick_cnt == STEP_LAST);
    pulses_done = (cur.pulse_cnt == cur.pulse_setting);
    vis_sum     = {1'b0, cur.vis_acc} + {7'h00, visible_channel_count_i};
    ir_sum      = {1'b0, cur.ir_acc} + {7'h00, infrared_channel_count_i};
    light_steps = STEPS_FULL - {1'b0, cur.light_integration_setting};
    wait_steps  = STEPS_FULL - {1'b0, cur.wait_time_setting};
    light_done  = tick && (cur.step_cnt + 9'h001 == light_steps);
    after_wait  = cur.light_en ? ST_LIGHT : ST_START;
    after_prox  = cur.wait_en ? ST_WAIT : after_wait;
    from_start  = cur.proximity_enable_bit ? ST_PROX : after_prox;
    next_cur    = cur;

    // --------------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------------
    if (reg_write_i) begin
      unique case (reg_addr_i)
        ADDR_ENABLE: begin
          next_cur.power_on_bit         = reg_wdata_i[BIT_POWER];
          next_cur.light_en             = reg_wdata_i[BIT_LIGHT_EN];
          next_cur.proximity_enable_bit = reg_wdata_i[BIT_PROX_EN];
          next_cur.wait_en              = reg_wdata_i[BIT_WAIT_EN];
        end
        ADDR_LIGHT_TIME: begin
          next_cur.light_integration_setting = reg_wdata_i;
        end
        ADDR_WAIT_TIME: begin
          next_cur.wait_time_setting = reg_wdata_i;
        end
        ADDR_PULSES: begin
          next_cur.pulse_setting = reg_wdata_i;
        end
        ADDR_GAIN: begin
          next_cur.light_gain_setting = reg_wdata_i[1:0];
        end
        // Unmapped addresses are ignored
        default: ;
      endcase
    end

    // --------------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------------
    // Answered in the next cycle only, zero otherwise
    next_cur.rdata = 8'h00;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        ADDR_ENABLE: begin
          next_cur.rdata[BIT_POWER]    = cur.power_on_bit;
          next_cur.rdata[BIT_LIGHT_EN] = cur.light_en;
          next_cur.rdata[BIT_PROX_EN]  = cur.proximity_enable_bit;
          next_cur.rdata[BIT_WAIT_EN]  = cur.wait_en;
        end
        ADDR_LIGHT_TIME: begin
          next_cur.rdata = cur.light_integration_setting;
        end
        ADDR_WAIT_TIME: begin
          next_cur.rdata = cur.wait_time_setting;
        end
        ADDR_PULSES: begin
          next_cur.rdata = cur.pulse_setting;
        end
        ADDR_GAIN: begin
          next_cur.rdata = {6'h00, cur.light_gain_setting};
        end
        ADDR_STATUS: begin
          next_cur.rdata       = {2'h0, cur.light_valid, cur.state};
          next_cur.light_valid = 1'b0;
        end
        // Low byte read freezes the high byte so a pair stays coherent
        ADDR_VIS_LO: begin
          next_cur.rdata         = cur.visible_channel_value[7:0];
          next_cur.vis_hi_shadow = cur.visible_channel_value[15:8];
        end
        ADDR_VIS_HI: begin
          next_cur.rdata = cur.vis_hi_shadow;
        end
        ADDR_IR_LO: begin
          next_cur.rdata        = cur.infrared_channel_value[7:0];
          next_cur.ir_hi_shadow = cur.infrared_channel_value[15:8];
        end
        ADDR_IR_HI: begin
          next_cur.rdata = cur.ir_hi_shadow;
        end
        default: ;
      endcase
    end

    // --------------------------------------------------------------------
    // Time base, shared by every step-timed state
    // --------------------------------------------------------------------
    next_cur.tick_cnt = tick ? '0 : cur.tick_cnt + STEP_W'(1);

    // --------------------------------------------------------------------
    // State walk
    // --------------------------------------------------------------------
    unique case (cur.state)
      ST_SLEEP: begin
        next_cur.tick_cnt = '0;
        // Wake on the enabling write itself so start follows at once
        if (next_cur.power_on_bit) begin
          next_cur.state = ST_START;
        end
      end

      ST_START: begin
        next_cur.tick_cnt  = '0;
        next_cur.step_cnt  = '0;
        next_cur.pulse_cnt = '0;
        next_cur.sub_cnt   = '0;
        next_cur.vis_acc   = '0;
        next_cur.ir_acc    = '0;
        next_cur.state = cur.power_on_bit ? from_start : ST_SLEEP;
      end

      ST_PROX: begin
        if (!pulses_done) begin
          // Time base is held during the LED burst
          next_cur.tick_cnt = '0;
          if (cur.sub_cnt == PULSE_LAST) begin
            next_cur.sub_cnt   = '0;
            next_cur.pulse_cnt = cur.pulse_cnt + 8'h01;
          end else begin
            next_cur.sub_cnt = cur.sub_cnt + PULSE_W'(1);
          end
        end else if (tick) begin
          next_cur.pulse_cnt = '0;
          next_cur.state = cur.power_on_bit ? after_prox : ST_SLEEP;
        end
      end

      ST_WAIT: begin
        // No conversion runs here, so power-off leaves at once
        if (!cur.power_on_bit) begin
          next_cur.step_cnt = '0;
          next_cur.state    = ST_SLEEP;
        end else if (tick) begin
          next_cur.step_cnt = cur.step_cnt + 9'h001;
          if (cur.step_cnt + 9'h001 == wait_steps) begin
            next_cur.step_cnt = '0;
            next_cur.state    = after_wait;
          end
        end
      end

      ST_LIGHT: begin
        if (tick) begin
          // Both channels accumulate on the same tick
          next_cur.vis_acc  = vis_sum[16] ? COUNT_FULL : vis_sum[15:0];
          next_cur.ir_acc   = ir_sum[16] ? COUNT_FULL : ir_sum[15:0];
          next_cur.step_cnt = cur.step_cnt + 9'h001;
        end
        if (light_done) begin
          next_cur.visible_channel_value  = next_cur.vis_acc;
          next_cur.infrared_channel_value = next_cur.ir_acc;
          next_cur.light_valid = 1'b1;
          next_cur.step_cnt    = '0;
          next_cur.vis_acc     = '0;
          next_cur.ir_acc      = '0;
          next_cur.state = cur.power_on_bit ? ST_START : ST_SLEEP;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur.state                     <= ST_SLEEP;
      cur.power_on_bit              <= 1'b0;
      cur.light_en                  <= 1'b0;
      cur.proximity_enable_bit      <= 1'b0;
      cur.wait_en                   <= 1'b0;
      cur.light_integration_setting <= SETTING_RST;
      cur.wait_time_setting         <= SETTING_RST;
      cur.pulse_setting             <= PULSES_RST;
      cur.light_gain_setting        <= GAIN_RST;
      cur.tick_cnt                  <= '0;
      cur.step_cnt                  <= '0;
      cur.pulse_cnt                 <= '0;
      cur.sub_cnt                   <= '0;
      cur.vis_acc                   <= '0;
      cur.ir_acc                    <= '0;
      cur.visible_channel_value     <= '0;
      cur.infrared_channel_value    <= '0;
      cur.vis_hi_shadow             <= '0;
      cur.ir_hi_shadow              <= '0;
      cur.light_valid               <= 1'b0;
      cur.rdata                     <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic pulsing;

  assign pulsing           = (cur.state == ST_PROX)
                             && (cur.pulse_cnt != cur.pulse_setting);
  assign reg_rdata_o       = cur.rdata;
  assign light_integrate_o = (cur.state == ST_LIGHT);
  assign light_gain_o      = cur.light_gain_setting;
  assign led_pulse_o       = pulsing && (cur.sub_cnt < LED_ON);
  assign prox_convert_o    = (cur.state == ST_PROX) && !pulsing;
  assign sleep_o           = (cur.state == ST_SLEEP);

endmodule // light_prox_sequencer
`default_nettype wire

// ==== light_prox_converter.sv ====
// Converter model that hands the sequencer fresh channel counts
`default_nettype none
module light_prox_converter (
  // Clock
  input  wire logic       ref_clk_i,
  // Counts per step
  output logic      [9:0] vis_o,
  output logic      [9:0] ir_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int seed = 2042;
  // New counts every cycle, so a sample on the wrong cycle is seen
  initial begin
    vis_o = 10'h000;
    ir_o  = 10'h000;
  end
  always @(posedge ref_clk_i) begin
    vis_o <= 10'($random(seed));
    ir_o  <= 10'($random(seed));
  end
endmodule // light_prox_converter
`default_nettype wire

// ==== light_prox_properties.sv ====
// Port checker for the light and proximity sequencer
`default_nettype none
module light_prox_properties
  import light_prox_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
) (
  // Watched ports
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [9:0] visible_channel_count_i,
  input wire logic [9:0] infrared_channel_count_i,
  input wire logic       light_integrate_o,
  input wire logic [1:0] light_gain_o,
  input wire logic       led_pulse_o,
  input wire logic       prox_convert_o,
  input wire logic       sleep_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // --------------------------------------------------------------------
  // Shadow of the settings
  // --------------------------------------------------------------------
  logic [7:0] en;
  logic [7:0] lset;
  logic [7:0] pset;
  logic       led_q;
  int         run;
  int         pulses;
  wire logic  wr_en = reg_write_i && reg_addr_i == ADDR_ENABLE;
  wire logic  pwr_wr = wr_en && reg_wdata_i[BIT_POWER];
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en     <= 8'h00;
      lset   <= SETTING_RST;
      pset   <= PULSES_RST;
      led_q  <= 1'b0;
      run    <= 0;
      pulses <= 0;
    end else begin
      if (wr_en) en <= reg_wdata_i;
      if (reg_write_i && reg_addr_i == ADDR_LIGHT_TIME) lset <= reg_wdata_i;
      if (reg_write_i && reg_addr_i == ADDR_PULSES) pset <= reg_wdata_i;
      led_q  <= led_pulse_o;
      run    <= light_integrate_o ? run + 1 : 0;
      pulses <= prox_convert_o ? 0 : pulses + int'(led_pulse_o && !led_q);
    end
  end
  sequence light_restart;
    ##1 light_integrate_o;
  endsequence
  // Power may drop on the last light edge, so start can come in between
  sequence sleep_next;
    ##[0:1] sleep_o;
  endsequence
  sleep_hold_a: assert property (sleep_o && !pwr_wr |=> sleep_o)
    else $error("sleep left without power bit");
  power_wake_a: assert property (sleep_o && pwr_wr |=> !sleep_o)
    else $error("power bit did not wake sequencer");
  sleep_quiet_a: assert property (
    sleep_o |-> !(light_integrate_o || led_pulse_o || prox_convert_o))
    else $error("activity while asleep");
  light_len_a: assert property ($fell(light_integrate_o) && run != 0
    |-> run == (256 - int'(lset)) * int'(STEP_CYCLES_P))
    else $error("light integration length wrong");
  light_follow_a: assert property (
    $fell(sleep_o) && en[3:1] == 3'b001 |-> light_restart)
    else $error("light state did not follow start");
  cycle_repeat_a: assert property (
    $fell(light_integrate_o) && en[3:0] == 4'b0011 |-> light_restart)
    else $error("cycle did not repeat");
  off_sleep_a: assert property (
    $fell(light_integrate_o) && !en[BIT_POWER] && run != 0 |-> sleep_next)
    else $error("no sleep after final conversion");
  prox_pulses_a: assert property (
    $rose(prox_convert_o) |-> pulses == int'(pset))
    else $error("led pulse count wrong");
endmodule // light_prox_properties
bind light_prox_sequencer light_prox_properties #(
  .STEP_CYCLES_P(STEP_CYCLES_P)
) props_i (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .visible_channel_count_i(visible_channel_count_i),
  .infrared_channel_count_i(infrared_channel_count_i),
  .light_integrate_o(light_integrate_o), .light_gain_o(light_gain_o),
  .led_pulse_o(led_pulse_o), .prox_convert_o(prox_convert_o),
  .sleep_o(sleep_o)
);
`default_nettype wire

// ==== light_prox_sensor_sequencer_tb.sv ====
// Self-checking bench for the light and proximity sequencer
`default_nettype none
module light_prox_sensor_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import light_prox_pkg::*;
  localparam int STEP = 4;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic  [7:0] reg_addr_i = 8'h00;
  logic  [7:0] reg_wdata_i = 8'h00;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i = 1'b0;
  logic  [7:0] reg_rdata_o;
  logic  [9:0] vis;
  logic  [9:0] ir;
  logic        light_integrate_o;
  logic        led_pulse_o;
  logic        prox_convert_o;
  logic        sleep_o;
  logic  [1:0] light_gain_o;
  logic [15:0] rst_tab [7] = '{16'h0000, 16'h01ff, 16'h03ff, 16'h0e00,
                               16'h0f00, 16'h1301, 16'h0200};
  logic [31:0] expq [$];
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          lset = 255;
  int          lrun = 0;
  int          accv = 0;
  int          acci = 0;
  light_prox_converter conv (.ref_clk_i(ref_clk_i), .vis_o(vis), .ir_o(ir));
  light_prox_sequencer #(.STEP_CYCLES_P(STEP)) dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .visible_channel_count_i(vis), .infrared_channel_count_i(ir),
    .light_integrate_o(light_integrate_o), .light_gain_o(light_gain_o),
    .led_pulse_o(led_pulse_o), .prox_convert_o(prox_convert_o),
    .sleep_o(sleep_o));
  always #2.5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Reference model: counts land on each STEP-th light cycle
  // --------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (light_integrate_o === 1'b1) begin
      lrun = lrun + 1;
      if (lrun % STEP == 0) begin
        accv = (accv + vis > 65535) ? 65535 : accv + vis;
        acci = (acci + ir > 65535) ? 65535 : acci + ir;
      end
    end else if (lrun != 0) begin
      chk(16'(lrun), 16'((256 - lset) * STEP));
      expq.push_back({acci[15:0], accv[15:0]});
      lrun = 0;
      accv = 0;
      acci = 0;
    end
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_read_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Waits are bounded by the cycle ceiling above
  task automatic waitfor(input int s, input logic v);
    #1;
    while ((s == 0 ? light_integrate_o : sleep_o) !== v) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask
  initial begin
    logic [7:0] d;
    int n;
    logic q;
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    chk(16'(sleep_o), 16'h0001);
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][15:8], d);
      chk(16'(d), 16'(rst_tab[i][7:0]));
    end
    wr(ADDR_ENABLE, 8'h01);
    #1 chk(16'(sleep_o), 16'h0000);
    rd(ADDR_ENABLE, d);
    chk(16'(d), 16'h0001);
    wr(ADDR_GAIN, 8'h03);
    #1 chk(16'(light_gain_o), 16'h0003);
    rd(ADDR_GAIN, d);
    chk(16'(d), 16'h0003);
    @(posedge ref_clk_i);
    #1 chk(16'(reg_rdata_o), 16'h0000);
    wr(ADDR_ENABLE, 8'h00);
    waitfor(1, 1'b1);
    $display("test reset and power done");
    // Single-step and full-length runs; the long one saturates
    for (n = 0; n < 2; n++) begin
      lset = n ? 0 : 255;
      wr(ADDR_LIGHT_TIME, 8'(lset));
      wr(ADDR_ENABLE, 8'h03);
      waitfor(0, 1'b1);
      waitfor(0, 1'b0);
      waitfor(0, 1'b1);
      wr(ADDR_ENABLE, 8'h00);
      waitfor(1, 1'b1);
      for (int b = 0; b < 4; b++) begin
        rd(ADDR_VIS_LO + 8'(b), d);
        chk(16'(d), 16'(expq[$][8*b +: 8]));
      end
      rd(ADDR_STATUS, d);
      chk(16'(d), 16'h0021);
      rd(ADDR_STATUS, d);
      chk(16'(d), 16'h0001);
      $display("test light run %0d done", lset);
    end
    wr(ADDR_PULSES, 8'h02);
    wr(ADDR_WAIT_TIME, 8'hfe);
    lset = 255;
    wr(ADDR_LIGHT_TIME, 8'hff);
    wr(ADDR_ENABLE, 8'h0f);
    n = 0;
    q = 1'b0;
    while (prox_convert_o !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
      if (led_pulse_o && !q) n++;
      q = led_pulse_o;
    end
    chk(16'(n), 16'h0002);
    while (prox_convert_o !== 1'b0) begin
      @(posedge ref_clk_i);
      #1;
    end
    n = 0;
    while (light_integrate_o !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(16'(n), 16'(2 * STEP));
    wr(ADDR_ENABLE, 8'h00);
    waitfor(1, 1'b1);
    $display("test proximity wait light done");
    test_done();
  end
endmodule // light_prox_sensor_sequencer_tb
`default_nettype wire
